// ==== rwc_reset_watchdog.sv ====
// Local design decisions: the AHB-Lite slave port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "rwc_map.svh"

module rwc_reset_watchdog
    import rwc_pkg::*;
#(
    parameter int SLOW_DIV = `RWC_SLOW_DIV
) (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // reset sources
    input  wire logic        pinResetReq,
    input  wire logic        illegalOpcodeReq,
    input  wire logic        illegalAddressReq,
    input  wire logic        lowVoltageReq,
    input  wire logic        debugResetReq,
    // system state
    input  wire logic        debugMode,
    input  wire logic        stopMode,
    input  wire logic        imaskClear,
    // vector fetch
    output logic             vecRead,
    output logic [15:0]      vecAddr,
    input  wire logic [7:0]  vecData,
    // cpu reset state
    output logic             systemReset,
    output logic [15:0]      programCounter,
    output logic             pcLoad,
    output logic [15:0]      stackPointer,
    output logic             interruptMask,
    output logic             periphEnable,
    output logic [7:0]       pinOutEnable,
    output logic [7:0]       pinPullEnable
);

    // ***********************************************
    // declarations
    // ***********************************************
    rwc_state_t  state_q;
    logic [7:0]  holdCnt_q;
    rwc_cause_t  cause_q;
    logic        wdEnable_q;
    logic        wdTimeout_q;
    logic        wdClkSel_q;
    logic        lockOne_q;
    logic        lockTwo_q;
    rwc_count_t  wdCount_q;
    rwc_count_t  wdLimit;
    logic        stopMode_q;
    logic        slowTick;
    logic        wdTick;
    logic        wdExpire;
    logic        anyReq;
    logic        svcClear;
    logic        wrPend_q;
    logic [7:0]  wrAddr_q;
    logic        addrPhase;
    logic        wrCause;
    logic        wrOptOne;
    logic        wrOptTwo;
    logic [7:0]  pcHigh_q;
    logic [31:0] rdData;

    // ***********************************************
    // slow tick source
    // ***********************************************
    rwc_tick_divider #(
        .DIV (SLOW_DIV)
    ) u_tick (
        .clk     (clk),
        .sys_rst (sys_rst),
        .tick    (slowTick)
    );

    // ***********************************************
    // bus decode
    // ***********************************************
    assign addrPhase = hsel & htrans[1] & hready;
    assign wrCause   = wrPend_q & (wrAddr_q == `RWC_ADDR_CAUSE);
    assign wrOptOne  = wrPend_q & (wrAddr_q == `RWC_ADDR_OPT_ONE) & ~lockOne_q;
    assign wrOptTwo  = wrPend_q & (wrAddr_q == `RWC_ADDR_OPT_TWO) & ~lockTwo_q;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            wrPend_q <= 1'b0;
            wrAddr_q <= 8'h00;
        end else begin
            wrPend_q <= addrPhase & hwrite;
            wrAddr_q <= {haddr[7:2], 2'b00};
        end
    end

    always_comb begin
        rdData = 32'h0;
        unique case ({haddr[7:2], 2'b00})
            `RWC_ADDR_CAUSE:   rdData[5:0] = cause_q;
            `RWC_ADDR_OPT_ONE: begin
                rdData[`RWC_OPT1_ENABLE]  = wdEnable_q;
                rdData[`RWC_OPT1_TIMEOUT] = wdTimeout_q;
            end
            `RWC_ADDR_OPT_TWO: rdData[`RWC_OPT2_CLKSEL] = wdClkSel_q;
            `RWC_ADDR_STATUS: begin
                rdData[`RWC_STAT_CNT_LSB +: 18] = wdCount_q;
                rdData[`RWC_STAT_LOCK1]         = lockOne_q;
                rdData[`RWC_STAT_LOCK2]         = lockTwo_q;
                rdData[`RWC_STAT_IMASK]         = interruptMask;
            end
            default:           rdData = 32'h0;
        endcase
    end

    // read data registered at the address phase, zero wait states
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            hrdata    <= 32'h0;
            hreadyout <= 1'b0;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            if (addrPhase && !hwrite) begin
                hrdata <= rdData;
            end
        end
    end

    // ***********************************************
    // reset sequencing
    // ***********************************************
    assign anyReq = pinResetReq | illegalOpcodeReq | illegalAddressReq
                  | lowVoltageReq | debugResetReq | wdExpire;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q   <= RWC_HOLD;
            holdCnt_q <= 8'h00;
        end else if (anyReq) begin
            state_q   <= RWC_HOLD;
            holdCnt_q <= 8'h00;
        end else begin
            unique case (state_q)
                RWC_HOLD: begin
                    holdCnt_q <= holdCnt_q + 8'h01;
                    if (holdCnt_q == `RWC_HOLD_CYCLES - 8'h01) begin
                        state_q <= RWC_VECHI;
                    end
                end
                RWC_VECHI: state_q <= RWC_VECLO;
                RWC_VECLO: state_q <= RWC_LOAD;
                RWC_LOAD:  state_q <= RWC_RUN;
                RWC_RUN:   state_q <= RWC_RUN;
            endcase
        end
    end

    // ***********************************************
    // reset cause capture
    // ***********************************************
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cause_q <= `RWC_CAUSE_RESET;
        end else if (debugResetReq) begin
            cause_q <= 6'h00;
        end else if (anyReq) begin
            cause_q <= 6'h00;
            if (lowVoltageReq) begin
                cause_q[`RWC_CAUSE_LVR] <= 1'b1;
            end else if (pinResetReq) begin
                cause_q[`RWC_CAUSE_PIN] <= 1'b1;
            end else if (illegalOpcodeReq) begin
                cause_q[`RWC_CAUSE_OPCODE] <= 1'b1;
            end else if (illegalAddressReq) begin
                cause_q[`RWC_CAUSE_BADADDR] <= 1'b1;
            end else begin
                cause_q[`RWC_CAUSE_WDOG] <= 1'b1;
            end
        end
    end

    // ***********************************************
    // write-once option registers
    // ***********************************************
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            wdEnable_q  <= `RWC_ENABLE_RESET;
            wdTimeout_q <= `RWC_TIMEOUT_RESET;
            lockOne_q   <= 1'b0;
        end else if (state_q == RWC_HOLD || anyReq) begin
            wdEnable_q  <= `RWC_ENABLE_RESET;
            wdTimeout_q <= `RWC_TIMEOUT_RESET;
            lockOne_q   <= 1'b0;
        end else if (wrOptOne) begin
            wdEnable_q  <= hwdata[`RWC_OPT1_ENABLE];
            wdTimeout_q <= hwdata[`RWC_OPT1_TIMEOUT];
            lockOne_q   <= 1'b1;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            wdClkSel_q <= `RWC_CLKSEL_RESET;
            lockTwo_q  <= 1'b0;
        end else if (state_q == RWC_HOLD || anyReq) begin
            wdClkSel_q <= `RWC_CLKSEL_RESET;
            lockTwo_q  <= 1'b0;
        end else if (wrOptTwo) begin
            wdClkSel_q <= hwdata[`RWC_OPT2_CLKSEL];
            lockTwo_q  <= 1'b1;
        end
    end

    // ***********************************************
    // watchdog counter
    // ***********************************************
    always_comb begin
        unique case ({wdClkSel_q, wdTimeout_q})
            2'b00: wdLimit = `RWC_LIM_SLOW_SHORT;
            2'b01: wdLimit = `RWC_LIM_SLOW_LONG;
            2'b10: wdLimit = `RWC_LIM_BUS_SHORT;
            2'b11: wdLimit = `RWC_LIM_BUS_LONG;
        endcase
    end

    // bus clock counts every cycle, slow clock on the divider tick
    assign wdTick = (wdClkSel_q ? 1'b1 : slowTick)
                  & wdEnable_q
                  & ~debugMode
                  & ~stopMode
                  & (state_q == RWC_RUN);

    assign wdExpire = wdTick & (wdCount_q == wdLimit);
    assign svcClear = wrCause | wrOptOne | wrOptTwo;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            stopMode_q <= 1'b0;
        end else begin
            stopMode_q <= stopMode;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            wdCount_q <= 18'h0;
        end else if (state_q != RWC_RUN || anyReq) begin
            wdCount_q <= 18'h0;
        end else if (svcClear) begin
            wdCount_q <= 18'h0;
        end else if (!wdClkSel_q && stopMode && !stopMode_q) begin
            wdCount_q <= 18'h0;
        end else if (wdTick) begin
            wdCount_q <= wdCount_q + 18'h1;
        end
    end

    // ***********************************************
    // vector fetch and cpu start state
    // ***********************************************
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            vecRead <= 1'b0;
            vecAddr <= `RWC_VEC_HI_ADDR;
        end else begin
            vecRead <= 1'b0;
            if (!anyReq && state_q == RWC_HOLD
                && holdCnt_q == `RWC_HOLD_CYCLES - 8'h01) begin
                vecRead <= 1'b1;
                vecAddr <= `RWC_VEC_HI_ADDR;
            end else if (!anyReq && state_q == RWC_VECHI) begin
                vecRead <= 1'b1;
                vecAddr <= `RWC_VEC_LO_ADDR;
            end
        end
    end

    // data returns the cycle after each read strobe
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pcHigh_q       <= 8'h00;
            programCounter <= 16'h0000;
            pcLoad         <= 1'b0;
        end else begin
            pcLoad <= 1'b0;
            if (state_q == RWC_VECLO) begin
                pcHigh_q <= vecData;
            end
            if (state_q == RWC_LOAD && !anyReq) begin
                programCounter <= {pcHigh_q, vecData};
                pcLoad         <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            stackPointer <= `RWC_STACK_INIT;
        end else if (state_q != RWC_RUN || anyReq) begin
            stackPointer <= `RWC_STACK_INIT;
        end
    end

    // set wins over a clear arriving in the same cycle
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            interruptMask <= 1'b1;
        end else if (state_q != RWC_RUN || anyReq) begin
            interruptMask <= 1'b1;
        end else if (imaskClear) begin
            interruptMask <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            systemReset   <= 1'b1;
            periphEnable  <= 1'b0;
            pinOutEnable  <= 8'h00;
            pinPullEnable <= 8'h00;
        end else begin
            systemReset   <= anyReq || state_q != RWC_RUN;
            periphEnable  <= !anyReq && state_q == RWC_RUN;
            pinOutEnable  <= 8'h00;
            pinPullEnable <= 8'h00;
        end
    end

endmodule

`default_nettype wire

// ==== rwc_map.svh ====
`ifndef RWC_MAP_SVH
`define RWC_MAP_SVH

// ***********************************************
// register byte addresses
// ***********************************************
`define RWC_ADDR_CAUSE      8'h00
`define RWC_ADDR_OPT_ONE    8'h04
`define RWC_ADDR_OPT_TWO    8'h08
`define RWC_ADDR_STATUS     8'h0c

// ***********************************************
// field positions
// ***********************************************
`define RWC_CAUSE_POR       0
`define RWC_CAUSE_PIN       1
`define RWC_CAUSE_WDOG      2
`define RWC_CAUSE_OPCODE    3
`define RWC_CAUSE_BADADDR   4
`define RWC_CAUSE_LVR       5
`define RWC_OPT1_ENABLE     0
`define RWC_OPT1_TIMEOUT    1
`define RWC_OPT2_CLKSEL     0
`define RWC_STAT_CNT_LSB    0
`define RWC_STAT_LOCK1      24
`define RWC_STAT_LOCK2      25
`define RWC_STAT_IMASK      26

// ***********************************************
// reset values
// ***********************************************
`define RWC_CAUSE_RESET     6'h01
`define RWC_ENABLE_RESET    1'b1
`define RWC_TIMEOUT_RESET   1'b1
`define RWC_CLKSEL_RESET    1'b0
`define RWC_STACK_INIT      16'h00ff
`define RWC_VEC_HI_ADDR     16'hfffe
`define RWC_VEC_LO_ADDR     16'hffff

// ***********************************************
// timing
// ***********************************************
`define RWC_CLK_PERIOD_NS   10
`define RWC_SLOW_PERIOD_NS  1000000
`define RWC_SLOW_DIV        (`RWC_SLOW_PERIOD_NS / `RWC_CLK_PERIOD_NS)
`define RWC_HOLD_CYCLES     8'h10
`define RWC_LIM_SLOW_SHORT  18'h0001f
`define RWC_LIM_SLOW_LONG   18'h000ff
`define RWC_LIM_BUS_SHORT   18'h01fff
`define RWC_LIM_BUS_LONG    18'h3ffff

`endif

// ==== rwc_pkg.sv ====
package rwc_pkg;

    typedef enum logic [4:0] {
        RWC_HOLD  = 5'b00001,
        RWC_VECHI = 5'b00010,
        RWC_VECLO = 5'b00100,
        RWC_LOAD  = 5'b01000,
        RWC_RUN   = 5'b10000
    } rwc_state_t;

    typedef logic [17:0] rwc_count_t;
    typedef logic [5:0]  rwc_cause_t;

endpackage

// ==== rwc_tick_divider.sv ====
`timescale 1ns/10ps
`default_nettype none

module rwc_tick_divider #(
    parameter int DIV = 100000
) (
    input  wire logic clk,
    input  wire logic sys_rst,
    output logic      tick
);

    logic [31:0] count_q;

    // ***********************************************
    // free running divider, one-cycle enable
    // ***********************************************
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            count_q <= 32'h0;
            tick    <= 1'b0;
        end else if (count_q == 32'(DIV - 1)) begin
            count_q <= 32'h0;
            tick    <= 1'b1;
        end else begin
            count_q <= count_q + 32'h1;
            tick    <= 1'b0;
        end
    end

endmodule

`default_nettype wire

// ==== rwc_reset_watchdog_properties.sv ====
`timescale 1ns/10ps
`default_nettype none
module rwc_reset_watchdog_checker (
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic        hsel,
    input wire logic [7:0]  haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        pinResetReq,
    input wire logic        illegalOpcodeReq,
    input wire logic        illegalAddressReq,
    input wire logic        lowVoltageReq,
    input wire logic        debugResetReq,
    input wire logic        imaskClear,
    input wire logic        vecRead,
    input wire logic [15:0] vecAddr,
    input wire logic [7:0]  vecData,
    input wire logic        systemReset,
    input wire logic [15:0] programCounter,
    input wire logic        pcLoad,
    input wire logic [15:0] stackPointer,
    input wire logic        interruptMask,
    input wire logic        periphEnable,
    input wire logic [7:0]  pinOutEnable,
    input wire logic [7:0]  pinPullEnable
);
    wire anyReq = pinResetReq | illegalOpcodeReq | illegalAddressReq | lowVoltageReq | debugResetReq;
    wire causeRd = hsel && htrans[1] && hready && !hwrite && (haddr == 8'h00);

    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);

    // ****************************************
    // vector fetch
    // ****************************************
    sequence fetchHigh;
        vecRead && (vecAddr == 16'hfffe);
    endsequence
    sequence fetchLow;
        vecRead && (vecAddr == 16'hffff);
    endsequence

    AST_VEC_ORDER: assert property (fetchHigh |=> fetchLow ##1 !vecRead ##1 pcLoad)
        else $error("vector fetch order wrong");
    AST_PC_VALUE: assert property (pcLoad |-> programCounter == {$past(vecData, 2), $past(vecData)})
        else $error("program counter not taken from vector");
    AST_RUN_AFTER_LOAD: assert property ($fell(systemReset) |-> $past(pcLoad))
        else $error("reset left without vector load");

    // ****************************************
    // reset state and bus responses
    // ****************************************
    AST_SP_RESET: assert property (systemReset |-> stackPointer == 16'h00ff)
        else $error("stack pointer wrong in reset");
    AST_IMASK_RESET: assert property (systemReset |-> interruptMask)
        else $error("interrupt mask clear in reset");
    AST_IMASK_CLEAR: assert property ($fell(interruptMask) |-> $past(imaskClear) && !$past(systemReset))
        else $error("interrupt mask cleared without request");
    AST_PINS_RESET: assert property (systemReset |-> !periphEnable && !(|pinOutEnable) && !(|pinPullEnable))
        else $error("pins or peripherals active in reset");
    AST_REQ_RESET: assert property (anyReq |=> systemReset [*8])
        else $error("reset request not honoured");
    AST_CAUSE_READ: assert property (causeRd |=> hrdata[31:6] == 26'h0)
        else $error("cause register upper bits set");
    AST_ZERO_WAIT: assert property (!$past(sys_rst) |-> hreadyout && !hresp)
        else $error("bus not ready or not okay");
endmodule

bind rwc_reset_watchdog rwc_reset_watchdog_checker rwc_reset_watchdog_checker_inst (
    .clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pinResetReq(pinResetReq),
    .illegalOpcodeReq(illegalOpcodeReq), .illegalAddressReq(illegalAddressReq), .lowVoltageReq(lowVoltageReq),
    .debugResetReq(debugResetReq), .imaskClear(imaskClear), .vecRead(vecRead), .vecAddr(vecAddr),
    .vecData(vecData), .systemReset(systemReset), .programCounter(programCounter), .pcLoad(pcLoad),
    .stackPointer(stackPointer), .interruptMask(interruptMask), .periphEnable(periphEnable),
    .pinOutEnable(pinOutEnable), .pinPullEnable(pinPullEnable));
`default_nettype wire

// ==== tb_rwc_reset_watchdog.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb_rwc_reset_watchdog;
    localparam int SDIV = 10;
    localparam logic [31:0] CAUSES [5] = '{32'h02, 32'h08, 32'h10, 32'h20, 32'h00};
    localparam logic [31:0] ALL = 32'hffffffff;

    logic        clk, sys_rst, hwrite, debugMode, stopMode, imaskClear, rdPend;
    logic [1:0]  htrans;
    logic [4:0]  req;
    logic [7:0]  haddr, vecData, vecHi, vecLo;
    logic [31:0] hwdata, seed;
    logic [31:0] expQ[$], mskQ[$];
    logic [15:0] pcQ[$];
    int          failures, checks;
    wire logic        hreadyout, hresp, vecRead, systemReset, pcLoad, interruptMask, periphEnable;
    wire logic [31:0] hrdata;
    wire logic [15:0] vecAddr, programCounter, stackPointer;
    wire logic [7:0]  pinOutEnable, pinPullEnable;

    rwc_reset_watchdog #(.SLOW_DIV(SDIV)) rwc_reset_watchdog_inst (
        .clk(clk), .sys_rst(sys_rst), .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .pinResetReq(req[0]), .illegalOpcodeReq(req[1]), .illegalAddressReq(req[2]),
        .lowVoltageReq(req[3]), .debugResetReq(req[4]), .debugMode(debugMode), .stopMode(stopMode),
        .imaskClear(imaskClear), .vecRead(vecRead), .vecAddr(vecAddr), .vecData(vecData),
        .systemReset(systemReset), .programCounter(programCounter), .pcLoad(pcLoad),
        .stackPointer(stackPointer), .interruptMask(interruptMask), .periphEnable(periphEnable),
        .pinOutEnable(pinOutEnable), .pinPullEnable(pinPullEnable));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic close_out;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic waitReady;
        int k;
        k = 0;
        @(posedge clk);
        while (hreadyout !== 1'b1 && k < 50) begin
            @(posedge clk);
            k++;
        end
        if (k >= 50) begin
            failures++;
            close_out();
        end
    endtask

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        htrans <= 2'b10;
        haddr  <= a;
        hwrite <= wr;
        waitReady();
        htrans <= 2'b00;
        hwdata <= d;
        waitReady();
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] msk);
        expQ.push_back(exp & msk);
        mskQ.push_back(msk);
        bus(1'b0, a, 32'h0);
    endtask

    // vector changes on every reset
    task automatic arm;
        seed = lfsr(seed);
        vecHi = seed[7:0];
        vecLo = seed[15:8];
        pcQ.push_back({seed[7:0], seed[15:8]});
    endtask

    task automatic waitRun;
        int k;
        k = 0;
        while (systemReset !== 1'b0 && k < 100) begin
            @(posedge clk);
            k++;
        end
        if (k >= 100) begin
            failures++;
            close_out();
        end
    endtask

    task automatic wdWait(input int lo, input int hi);
        int k;
        k = 0;
        while (systemReset !== 1'b1 && k <= hi) begin
            @(posedge clk);
            k++;
        end
        chk({31'h0, k >= lo && k <= hi}, 32'h1);
        if (k > hi) begin
            close_out();
        end
    endtask

    // ****************************************
    // memory and monitor
    // ****************************************
    // released data line shows inverted pattern
    always @(posedge clk) begin
        vecData <= vecRead ? ((vecAddr == 16'hfffe) ? vecHi : vecLo) : ~vecData;
    end

    always @(posedge clk) begin
        if (rdPend && hreadyout === 1'b1) begin
            chk(hrdata & mskQ[0], expQ[0]);
            expQ.delete(0);
            mskQ.delete(0);
        end
        if (pcLoad === 1'b1) begin
            chk({16'h0, programCounter}, {16'h0, pcQ[0]});
            pcQ.delete(0);
        end
        rdPend <= !sys_rst && ((htrans[1] && !hwrite && hreadyout === 1'b1) || (rdPend && hreadyout !== 1'b1));
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        sys_rst = 1'b1;
        htrans = 2'b00;
        haddr = 8'h00;
        hwrite = 1'b0;
        hwdata = 32'h0;
        req = 5'h00;
        debugMode = 1'b0;
        stopMode = 1'b0;
        imaskClear = 1'b0;
        vecData = 8'h00;
        rdPend = 1'b0;
        seed = 32'd85607;
        failures = 0;
        checks = 0;
        arm();
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        waitRun();
        rd(8'h00, 32'h01, ALL);
        rd(8'h04, 32'h03, ALL);
        rd(8'h08, 32'h00, ALL);
        rd(8'h0c, 32'h04000000, 32'h07000000);
        rd(8'h10, 32'h0, ALL);
        chk({31'h0, periphEnable}, 32'h1);
        $display("test power-on done");

        debugMode <= 1'b1;
        bus(1'b1, 8'h04, 32'h03);
        bus(1'b1, 8'h08, 32'h01);
        seed = lfsr(seed);
        bus(1'b1, 8'h00, seed);
        repeat (30) @(posedge clk);
        rd(8'h00, 32'h01, ALL);
        rd(8'h0c, 32'h07000000, 32'h0703ffff);
        stopMode <= 1'b1;
        debugMode <= 1'b0;
        repeat (30) @(posedge clk);
        rd(8'h0c, 32'h0, 32'h0003ffff);
        bus(1'b1, 8'h04, 32'h00);
        bus(1'b1, 8'h08, 32'h00);
        rd(8'h04, 32'h03, ALL);
        rd(8'h08, 32'h01, ALL);
        imaskClear <= 1'b1;
        @(posedge clk);
        imaskClear <= 1'b0;
        rd(8'h0c, 32'h0, 32'h04000000);
        stopMode <= 1'b0;
        repeat (8300) @(posedge clk);
        chk({31'h0, systemReset}, 32'h0);
        $display("test lock and hold done");

        for (int i = 0; i < 5; i++) begin
            arm();
            req <= 5'h01 << i;
            @(posedge clk);
            req <= 5'h00;
            @(posedge clk);
            waitRun();
            rd(8'h00, CAUSES[i], ALL);
            rd(8'h04, 32'h03, ALL);
            rd(8'h0c, 32'h0, 32'h03000000);
        end
        $display("test reset sources done");

        bus(1'b1, 8'h04, 32'h01);
        bus(1'b1, 8'h08, 32'h01);
        arm();
        wdWait(8188, 8198);
        debugMode <= 1'b1;
        waitRun();
        rd(8'h00, 32'h04, ALL);
        rd(8'h0c, 32'h0, 32'h0003ffff);
        debugMode <= 1'b0;
        $display("test bus expiry done");

        bus(1'b1, 8'h04, 32'h01);
        bus(1'b1, 8'h08, 32'h00);
        repeat (200) @(posedge clk);
        seed = lfsr(seed);
        bus(1'b1, 8'h00, seed);
        arm();
        wdWait(320 - SDIV - 4, 320 + SDIV + 4);
        waitRun();
        rd(8'h00, 32'h04, ALL);
        $display("test slow expiry done");

        repeat (200) @(posedge clk);
        stopMode <= 1'b1;
        repeat (5) @(posedge clk);
        rd(8'h0c, 32'h0, 32'h0003ffff);
        stopMode <= 1'b0;
        arm();
        wdWait(2560 - SDIV - 4, 2560 + SDIV + 4);
        waitRun();
        $display("test stop clear done");

        bus(1'b1, 8'h04, 32'h00);
        repeat (2700) @(posedge clk);
        chk({31'h0, systemReset}, 32'h0);
        $display("test disable done");
        close_out();
    end
endmodule
`default_nettype wire
